// [src/ssrc_pkg.sv]
/*
 * package for the single-slope ramp counter: widths, ramp scaling, fault threshold,
 * and the structs that carry the converter's inputs and ladder level.
 * assumes the analog front end is digitised into millivolt codes outside this block.
 */
package ssrc_pkg;
	// ==========================================================
	// counter and ladder
	localparam int          CNT_W          = 7;
	localparam logic [6:0]  CNT_RESET      = 7'h00;
	localparam int          LVL_W          = 16;
	// supply level in millivolts; ramp spans 3/4 down to 1/4 of it
	localparam logic [15:0] SUPPLY_MV      = 16'h1400;
	localparam logic [15:0] RAMP_TOP_MV    = 16'(SUPPLY_MV * 3 / 4);
	localparam logic [15:0] RAMP_SPAN_MV   = 16'(SUPPLY_MV / 2);
	// ==========================================================
	// fault comparator
	localparam int          FAULT_MV_INT   = 200;
	localparam logic [15:0] FAULT_MV       = 16'(FAULT_MV_INT);

	typedef struct packed {
		logic        enable;
		logic        clear;
		logic [15:0] analog_mv;
	} ssrc_in_t;

	typedef struct packed {
		logic [6:0]  count;
		logic [15:0] ladder_ramp_level;
	} ssrc_ramp_t;
endpackage : ssrc_pkg

// [src/ssrc_top.sv]
/*
 * digital part of a 7-bit single-slope converter: counter, binary ladder sum,
 * ramp and fault comparators, gated pulse-width output.
 * assumes an external controller supplies count clock, reset and enable pins,
 * and the analog input arrives as a millivolt code in the ref_clk domain.
 */
`timescale 1ns/1ps

// Overview of operation
// - seven-bit synchronous counter driven by clock
// - counter advances on falling count clock
// - each bit adds binary-weighted ramp step
// - ramp falls three quarters to one quarter
// - reset high with enable high clears counter, ramp top
// - output high while ramp exceeds input
// - input below 200 mV forces low while enabled
// - open reset and enable read low
module ssrc_top (
	input  wire logic               ref_clk,
	input  wire logic               rst_n,
	input  wire logic               clk_en,
	input  wire logic               count_clk_pin,
	input  wire logic               clear_pin,
	input  wire logic               enable_pin,
	input  wire logic [15:0]        analog_mv,
	output      logic               pwm_out,
	output      ssrc_pkg::ssrc_ramp_t ramp
);
	// ==========================================================
	// pin synchronisers; the external count clock is sampled, not used as a clock
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic       cclk_prev;
	ssrc_pkg::ssrc_in_t in_s;

	// the count clock bit resets to its idle high level so that release of reset
	// cannot look like a falling edge; clear and enable reset low like their pull-downs
	// latency: pin change reaches sync2 after two edges, count after three, ramp after four
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1     <= 3'h4;
			sync2     <= 3'h4;
			cclk_prev <= 1'b1;
		end else if (clk_en) begin
			sync1     <= {count_clk_pin, clear_pin, enable_pin};
			sync2     <= sync1;
			cclk_prev <= sync2[2];
		end
	end

	always_comb begin
		in_s.enable    = sync2[0];
		in_s.clear     = sync2[1];
		in_s.analog_mv = analog_mv;
	end

	logic fall_edge;
	assign fall_edge = cclk_prev & ~sync2[2];

	// ==========================================================
	// counter
	logic [6:0] count;
	logic [6:0] next_count;

	always_comb begin
		next_count = count;
		if (in_s.enable && in_s.clear) begin
			next_count = ssrc_pkg::CNT_RESET;
		end else if (fall_edge) begin
			next_count = 7'(count + 7'h01);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= ssrc_pkg::CNT_RESET;
		end else if (clk_en) begin
			count <= next_count;
		end
	end

	// ==========================================================
	// ladder sum: each set bit subtracts its binary weight of span/128
	logic [22:0] weight_sum;
	logic [15:0] level;

	always_comb begin
		weight_sum = 23'h0;
		for (int b = 0; b < ssrc_pkg::CNT_W; b++) begin
			if (count[b]) begin
				weight_sum = 23'(weight_sum + (23'(ssrc_pkg::RAMP_SPAN_MV) << b));
			end
		end
		level = 16'(ssrc_pkg::RAMP_TOP_MV - 16'(weight_sum >> 7));
	end

	// ==========================================================
	// output; registered so data output comes from a flip-flop
	logic next_pwm;

	always_comb begin
		if (!in_s.enable) begin
			next_pwm = 1'b1;
		end else if (in_s.analog_mv < ssrc_pkg::FAULT_MV) begin
			next_pwm = 1'b0;
		end else begin
			next_pwm = (level > in_s.analog_mv);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_out                <= 1'b1;
			ramp.count             <= ssrc_pkg::CNT_RESET;
			ramp.ladder_ramp_level <= ssrc_pkg::RAMP_TOP_MV;
		end else if (clk_en) begin
			pwm_out                <= next_pwm;
			ramp.count             <= count;
			ramp.ladder_ramp_level <= level;
		end
	end

	// ==========================================================
	// checks
	chk_clear_zeroes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && in_s.enable && in_s.clear |=> count == 7'h00)
		else $error("counter not cleared");
	chk_clear_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !in_s.enable && !fall_edge |=> count == $past(count))
		else $error("counter moved while disabled");
	chk_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && fall_edge && !(in_s.enable && in_s.clear) |=> count == 7'($past(count) + 7'h01))
		else $error("counter did not step on falling edge");
	chk_no_rise_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !fall_edge && !(in_s.enable && in_s.clear) |=> $stable(count))
		else $error("counter stepped without falling edge");
	chk_ramp_top: assert property (@(posedge ref_clk) disable iff (!rst_n)
		count == 7'h00 |-> level == ssrc_pkg::RAMP_TOP_MV)
		else $error("ramp not at top at zero");
	chk_ramp_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
		count != 7'h00 |-> level < ssrc_pkg::RAMP_TOP_MV && level > 16'(ssrc_pkg::RAMP_TOP_MV - ssrc_pkg::RAMP_SPAN_MV))
		else $error("ramp outside span");
	chk_out_disabled: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !in_s.enable |=> pwm_out)
		else $error("output low while disabled");
	chk_out_fault: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && in_s.enable && in_s.analog_mv < ssrc_pkg::FAULT_MV |=> !pwm_out)
		else $error("fault did not force low");
	chk_out_compare: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && in_s.enable && in_s.analog_mv >= ssrc_pkg::FAULT_MV |=> pwm_out == $past(level > in_s.analog_mv))
		else $error("compare output wrong");

	// ==========================================================
	// freeze, mirror and ladder checks
	// clk_en low must hold every flop, including the synchronisers, or an edge
	// seen during a freeze would be counted late once the block resumes
	chk_freeze_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable(count))
		else $error("counter moved while frozen");

	chk_freeze_out: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable(pwm_out) && $stable(ramp))
		else $error("outputs moved while frozen");

	chk_freeze_sync: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!clk_en |=> $stable(sync2) && $stable(cclk_prev))
		else $error("synchroniser moved while frozen");

	chk_sync_depth: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> sync2 == $past(sync1))
		else $error("synchroniser stage skipped");

	chk_ramp_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> ramp.count == $past(count))
		else $error("ramp count not registered");

	chk_level_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en |=> ramp.ladder_ramp_level == $past(level))
		else $error("ramp level not registered");

	chk_wrap_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && fall_edge && count == 7'h7f && !(in_s.enable && in_s.clear) |=> count == 7'h00)
		else $error("counter did not wrap");

	// one count must move the ramp by exactly one ladder step, never more
	chk_step_size: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && fall_edge && count != 7'h7f && !(in_s.enable && in_s.clear)
		|=> 16'($past(level) - level) == 16'(ssrc_pkg::RAMP_SPAN_MV >> 7))
		else $error("ramp step size wrong");

	chk_clear_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !in_s.enable && in_s.clear && !fall_edge |=> $stable(count))
		else $error("clear acted while disabled");

	chk_clear_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && in_s.enable && in_s.clear ##1 clk_en |=> ramp.ladder_ramp_level == ssrc_pkg::RAMP_TOP_MV)
		else $error("clear did not set ramp top");

	chk_fault_over_ramp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && in_s.enable && in_s.analog_mv < ssrc_pkg::FAULT_MV && level > in_s.analog_mv
		|=> !pwm_out)
		else $error("ramp overrode fault");

	chk_out_high_ramp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && in_s.enable && in_s.analog_mv >= ssrc_pkg::FAULT_MV && level > in_s.analog_mv
		|=> pwm_out)
		else $error("output low while ramp above input");

	chk_out_low_ramp: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && in_s.enable && in_s.analog_mv >= ssrc_pkg::FAULT_MV && level <= in_s.analog_mv
		|=> !pwm_out)
		else $error("output high while input above ramp");

	cov_freeze: cover property (@(posedge ref_clk) disable iff (!rst_n) !clk_en ##1 clk_en);
	cov_wrap: cover property (@(posedge ref_clk) disable iff (!rst_n) count == 7'h7f ##1 count == 7'h00);
	cov_measure: cover property (@(posedge ref_clk) disable iff (!rst_n) in_s.enable && pwm_out ##1 !pwm_out);
	cov_fault: cover property (@(posedge ref_clk) disable iff (!rst_n) in_s.enable && in_s.analog_mv < ssrc_pkg::FAULT_MV);
	cov_clear: cover property (@(posedge ref_clk) disable iff (!rst_n) in_s.enable && in_s.clear);
endmodule : ssrc_top

// [dv/ssrc_ctrl_model.sv]
/* controller model: drives the count clock, clear and enable pins.
   assumes the bench calls its tasks from one process only. */
`timescale 1ns/1ps
module ssrc_ctrl_model (
	input  wire logic ref_clk,
	output      logic count_clk_pin,
	output      logic clear_pin,
	output      logic enable_pin
);
	// ==========================================
	// pin drive
	initial begin
		count_clk_pin = 1'b1;
		clear_pin = 1'b0;
		enable_pin = 1'b0;
	end
	task automatic pins(input logic clr, input logic en);
		@(posedge ref_clk);
		#1 clear_pin = clr;
		enable_pin = en;
		repeat (6) @(posedge ref_clk);
	endtask : pins
	// low half periods of 4 cycles and high of 5 clear the 3-cycle minimum; clock idles high
	task automatic step(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1 count_clk_pin = 1'b0;
			repeat (4) @(posedge ref_clk);
			#1 count_clk_pin = 1'b1;
			repeat (4) @(posedge ref_clk);
		end
	endtask : step
endmodule : ssrc_ctrl_model

// [dv/single_slope_ramp_counter_tb_top.sv]
/* bench for the ramp counter: reset, counting, compare, fault, gating, wrap.
   assumes the controller model owns the three control pins. */
`timescale 1ns/1ps
module single_slope_ramp_counter_tb_top;
	logic                 ref_clk;
	logic                 rst_n;
	logic                 clk_en;
	logic [15:0]          analog_mv;
	logic                 count_clk_pin;
	logic                 clear_pin;
	logic                 enable_pin;
	logic                 pwm_out;
	ssrc_pkg::ssrc_ramp_t ramp;
	int                   n_fail = 0;
	int                   checks_done = 0;
	ssrc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.count_clk_pin(count_clk_pin), .clear_pin(clear_pin), .enable_pin(enable_pin),
		.analog_mv(analog_mv), .pwm_out(pwm_out), .ramp(ramp));
	ssrc_ctrl_model u_ctrl (.ref_clk(ref_clk), .count_clk_pin(count_clk_pin),
		.clear_pin(clear_pin), .enable_pin(enable_pin));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ==========================================
	// checks
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// one ramp step is span/128, so level never drifts from the count
	task automatic cmp_ramp(input logic [6:0] c);
		logic [15:0] lvl;
		#1;
		lvl = ssrc_pkg::RAMP_TOP_MV - {9'h000, c} * (ssrc_pkg::RAMP_SPAN_MV / 16'h0080);
		cmp("count", {9'h000, c}, {9'h000, ramp.count});
		cmp("level", lvl, ramp.ladder_ramp_level);
	endtask : cmp_ramp
	task automatic set_an(input logic [15:0] v);
		@(posedge ref_clk);
		#1 analog_mv = v;
		repeat (3) @(posedge ref_clk);
		#1;
	endtask : set_an
	// ==========================================
	// scenarios
	task automatic t_reset;
		@(posedge ref_clk);
		#1 cmp("pwm_out", 16'h0001, {15'h0000, pwm_out});
		cmp_ramp(7'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_count;
		u_ctrl.pins(1'b1, 1'b1);
		u_ctrl.pins(1'b0, 1'b1);
		u_ctrl.step(5);
		cmp_ramp(7'h05);
		$display("test count done");
	endtask : t_count
	task automatic t_compare;
		set_an(16'h0e9d);
		cmp("pwm_out", 16'h0000, {15'h0000, pwm_out});
		set_an(16'h0e9b);
		cmp("pwm_out", 16'h0001, {15'h0000, pwm_out});
		set_an(16'h00c7);
		cmp("pwm_out", 16'h0000, {15'h0000, pwm_out});
		set_an(16'h00c8);
		cmp("pwm_out", 16'h0001, {15'h0000, pwm_out});
		$display("test compare done");
	endtask : t_compare
	task automatic t_gate;
		u_ctrl.pins(1'b0, 1'b0);
		set_an(16'h00c7);
		cmp("pwm_out", 16'h0001, {15'h0000, pwm_out});
		u_ctrl.pins(1'b1, 1'b0);
		cmp_ramp(7'h05);
		u_ctrl.pins(1'b1, 1'b1);
		cmp_ramp(7'h00);
		u_ctrl.pins(1'b0, 1'b1);
		$display("test gate done");
	endtask : t_gate
	task automatic t_wrap;
		set_an(16'h0800);
		u_ctrl.step(127);
		cmp_ramp(7'h7f);
		u_ctrl.step(1);
		cmp_ramp(7'h00);
		$display("test wrap done");
	endtask : t_wrap
	task automatic t_freeze;
		@(posedge ref_clk);
		#1 clk_en = 1'b0;
		u_ctrl.step(2);
		cmp_ramp(7'h00);
		@(posedge ref_clk);
		#1 clk_en = 1'b1;
		repeat (6) @(posedge ref_clk);
		cmp_ramp(7'h00);
		u_ctrl.step(1);
		cmp_ramp(7'h01);
		$display("test freeze done");
	endtask : t_freeze
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		analog_mv = 16'h0800;
		repeat (3) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_count();
		t_compare();
		t_gate();
		t_wrap();
		t_freeze();
		test_done();
	end
endmodule : single_slope_ramp_counter_tb_top
